// ### sgx_expander.sv
`default_nettype none
module sgx_expander (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic reset_n_in,
  input wire logic spi_sclk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_si_in,
  output logic spi_so_out,
  input wire logic [sgx_pkg::NPINS-1:0] gpio_pins_in,
  output logic [sgx_pkg::NPINS-1:0] gpio_pins_out,
  output logic [sgx_pkg::NPINS-1:0] gpio_pins_oe_out,
  output logic [sgx_pkg::NPINS-1:0] gpio_pullup_en_out,
  output logic irq_n_out,
  output logic irq_n_oe_out
);
  import sgx_pkg::*;

  // three-stage samplers for every async input
  logic [2:0] sclk_s_ff, cs_s_ff, si_s_ff, rstn_s_ff;
  logic [2:0] pin_s_ff [NPINS];
  logic sclk_ff, cs_n_ff, si_ff, rstn_ff;
  logic [NPINS-1:0] pin_ff;
  logic sclk_prev_ff;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sclk_s_ff <= 3'h0;
      cs_s_ff <= 3'h7;
      si_s_ff <= 3'h0;
      rstn_s_ff <= 3'h7;
      sclk_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      si_ff <= 1'b0;
      rstn_ff <= 1'b1;
      sclk_prev_ff <= 1'b0;
    end else begin
      sclk_s_ff <= {sclk_s_ff[1:0], spi_sclk_in};
      cs_s_ff <= {cs_s_ff[1:0], spi_cs_n_in};
      si_s_ff <= {si_s_ff[1:0], spi_si_in};
      rstn_s_ff <= {rstn_s_ff[1:0], reset_n_in};
      if (sclk_s_ff[1] == sclk_s_ff[2]) sclk_ff <= sclk_s_ff[2];
      if (cs_s_ff[1] == cs_s_ff[2]) cs_n_ff <= cs_s_ff[2];
      if (si_s_ff[1] == si_s_ff[2]) si_ff <= si_s_ff[2];
      if (rstn_s_ff[1] == rstn_s_ff[2]) rstn_ff <= rstn_s_ff[2];
      sclk_prev_ff <= sclk_ff;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pin_sync
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          pin_s_ff[gi] <= 3'h0;
          pin_ff[gi] <= 1'b0;
        end else begin
          pin_s_ff[gi] <= {pin_s_ff[gi][1:0], gpio_pins_in[gi]};
          if (pin_s_ff[gi][1] == pin_s_ff[gi][2]) pin_ff[gi] <= pin_s_ff[gi][2];
        end
      end
    end
  endgenerate

  // pin reset must stay low for at least the minimum before it counts
  logic [2:0] rst_cnt_ff;
  logic pin_rst;
  always_ff @(posedge clk_in) begin
    if (rst_in || rstn_ff) rst_cnt_ff <= 3'h0;
    else if (rst_cnt_ff != RST_CNT_LAST) rst_cnt_ff <= rst_cnt_ff + 3'h1;
  end
  assign pin_rst = rst_in || (rst_cnt_ff == RST_CNT_LAST);

  logic sclk_rise, sclk_fall;
  assign sclk_rise = sclk_ff && !sclk_prev_ff;
  assign sclk_fall = !sclk_ff && sclk_prev_ff;

  // serial engine
  sgx_phase_t phase_ff;
  logic [BIT_CNT_W-1:0] bit_cnt_ff;
  logic [7:0] shin_ff, shout_ff;
  logic rd_ff;
  logic [5:0] ofs_ff;
  logic [7:0] nxt_byte;
  logic byte_done;
  logic data_seen_ff;
  logic wr_stb, rd_stb;
  logic [7:0] rd_data;

  assign nxt_byte = {shin_ff[6:0], si_ff};
  assign byte_done = !cs_n_ff && sclk_rise && (bit_cnt_ff == BIT_LAST);
  // no auto-increment: bytes after the first data byte are dropped
  assign wr_stb = byte_done && (phase_ff == SGX_DATA) && !rd_ff && !data_seen_ff;
  // read strobe when the command byte ends: read data is latched then
  assign rd_stb = byte_done && (phase_ff == SGX_CMD) && nxt_byte[CMD_RW_BIT];

  always_ff @(posedge clk_in) begin
    if (rst_in || cs_n_ff) begin
      phase_ff <= SGX_CMD;
      bit_cnt_ff <= '0;
      shin_ff <= RST_ZERO;
      rd_ff <= 1'b0;
      ofs_ff <= 6'h00;
      data_seen_ff <= 1'b0;
    end else if (sclk_rise) begin
      shin_ff <= nxt_byte;
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      if (byte_done && phase_ff == SGX_DATA) data_seen_ff <= 1'b1;
      if (byte_done && phase_ff == SGX_CMD) begin
        phase_ff <= SGX_DATA;
        rd_ff <= nxt_byte[CMD_RW_BIT];
        ofs_ff <= nxt_byte[CMD_OFS_HI:CMD_OFS_LO];
      end
    end
  end

  // output shifter: load on read strobe, shift on falling edge
  always_ff @(posedge clk_in) begin
    if (rst_in || cs_n_ff) begin
      shout_ff <= RST_ZERO;
      spi_so_out <= 1'b0;
    end else if (rd_stb) begin
      shout_ff <= rd_data;
    end else if (sclk_fall && phase_ff == SGX_DATA && rd_ff) begin
      spi_so_out <= shout_ff[7];
      shout_ff <= {shout_ff[6:0], 1'b0};
    end
  end

  // configuration registers
  logic [7:0] out_lvl_ff, pol_ff, dir_ff, pullup_ff, irq_en_ff, tri_ff, rise_ff, fall_ff;
  always_ff @(posedge clk_in) begin
    if (pin_rst) begin
      out_lvl_ff <= RST_ZERO;
      pol_ff <= RST_ZERO;
      dir_ff <= RST_ZERO;
      pullup_ff <= RST_ZERO;
      irq_en_ff <= RST_ZERO;
      tri_ff <= RST_ZERO;
      rise_ff <= RST_ZERO;
      fall_ff <= RST_ZERO;
    end else if (wr_stb) begin
      case (ofs_ff)
        OFS_OUT_LVL: out_lvl_ff <= nxt_byte;
        OFS_POLARITY: pol_ff <= nxt_byte;
        OFS_DIR: dir_ff <= nxt_byte;
        OFS_PULLUP: pullup_ff <= nxt_byte;
        OFS_IRQ_EN: irq_en_ff <= nxt_byte;
        OFS_TRISTATE: tri_ff <= nxt_byte;
        OFS_RISE_EN: rise_ff <= nxt_byte;
        OFS_FALL_EN: fall_ff <= nxt_byte;
        default: ;
      endcase
    end
  end

  // input state and interrupt tracking
  logic [7:0] in_state, pend_ff, ref_ff;
  assign in_state = pin_ff ^ pol_ff;
  logic in_rd;
  assign in_rd = rd_stb && (nxt_byte[CMD_OFS_HI:CMD_OFS_LO] == OFS_INPUT);

  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_irq
      logic rise_ev, fall_ev, trig;
      assign rise_ev = in_state[gi] && !ref_ff[gi];
      assign fall_ev = !in_state[gi] && ref_ff[gi];
      assign trig = !dir_ff[gi] && irq_en_ff[gi]
                    && ((rise_ev && rise_ff[gi]) || (fall_ev && fall_ff[gi]));
      always_ff @(posedge clk_in) begin
        if (pin_rst) begin
          pend_ff[gi] <= 1'b0;
          ref_ff[gi] <= 1'b0;
        end else if (pend_ff[gi]) begin
          // reference holds pre-change level until cleared
          if (in_state[gi] == ref_ff[gi]) pend_ff[gi] <= 1'b0;
          else if (in_rd) begin
            pend_ff[gi] <= 1'b0;
            ref_ff[gi] <= in_state[gi];
          end
        end else if (trig) begin
          pend_ff[gi] <= 1'b1;
        end else begin
          ref_ff[gi] <= in_state[gi];
        end
      end
    end
  endgenerate

  always_comb begin
    case (nxt_byte[CMD_OFS_HI:CMD_OFS_LO])
      OFS_INPUT: rd_data = in_state;
      OFS_OUT_LVL: rd_data = out_lvl_ff;
      OFS_POLARITY: rd_data = pol_ff;
      OFS_DIR: rd_data = dir_ff;
      OFS_PULLUP: rd_data = pullup_ff;
      OFS_IRQ_EN: rd_data = irq_en_ff;
      OFS_TRISTATE: rd_data = tri_ff;
      OFS_IRQ_STAT: rd_data = pend_ff;
      OFS_RISE_EN: rd_data = rise_ff;
      OFS_FALL_EN: rd_data = fall_ff;
      default: rd_data = RD_UNMAPPED;
    endcase
  end

  // pin drivers registered so pins never glitch on decode
  always_ff @(posedge clk_in) begin
    if (pin_rst) begin
      gpio_pins_out <= RST_ZERO;
      gpio_pins_oe_out <= RST_ZERO;
      gpio_pullup_en_out <= RST_ZERO;
      irq_n_out <= 1'b0;
      irq_n_oe_out <= 1'b0;
    end else begin
      gpio_pins_out <= out_lvl_ff;
      gpio_pins_oe_out <= dir_ff & ~tri_ff;
      gpio_pullup_en_out <= pullup_ff;
      irq_n_out <= 1'b0;
      irq_n_oe_out <= |(pend_ff & irq_en_ff);
    end
  end
endmodule
`default_nettype wire

// ### sgx_expander_asserts.sv
`default_nettype none
module sgx_expander_asserts (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic reset_n_in,
  input wire logic spi_sclk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_si_in,
  input wire logic spi_so_out,
  input wire logic [7:0] gpio_pins_in,
  input wire logic [7:0] gpio_pins_out,
  input wire logic [7:0] gpio_pins_oe_out,
  input wire logic [7:0] gpio_pullup_en_out,
  input wire logic irq_n_out,
  input wire logic irq_n_oe_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_quiet;
    (spi_cs_n_in && reset_n_in)[*8];
  endsequence
  sequence s_deselect;
    spi_cs_n_in[*8];
  endsequence
  a_irq_open_drain: assert property (irq_n_out == 1'b0)
    else $error("interrupt pin value not low");
  a_rst_outputs_zero: assert property (disable iff (1'b0) rst_in |=>
    (gpio_pins_oe_out | gpio_pullup_en_out | gpio_pins_out) == 8'h00 && !irq_n_oe_out)
    else $error("outputs not cleared by reset");
  a_so_idle_zero: assert property (s_deselect |-> spi_so_out == 1'b0)
    else $error("serial output active while deselected");
  a_so_hold_high: assert property (spi_sclk_in[*2] |=> $stable(spi_so_out))
    else $error("serial output moved while clock high");
  a_cfg_idle_stable: assert property (s_quiet |=> $stable(gpio_pins_oe_out)
    && $stable(gpio_pins_out)) else $error("pin drive changed without access");
  a_pu_idle_stable: assert property (s_quiet |=> $stable(gpio_pullup_en_out))
    else $error("pull-up changed without access");
  a_irq_needs_edge: assert property (($stable(gpio_pins_in) && spi_cs_n_in)[*8]
    |=> !$rose(irq_n_oe_out)) else $error("interrupt without input edge");
  a_pin_reset_clears: assert property ((!reset_n_in)[*8] |=>
    (gpio_pins_oe_out | gpio_pullup_en_out) == 8'h00 && !irq_n_oe_out)
    else $error("reset pin did not clear");
endmodule
bind sgx_expander sgx_expander_asserts u_chk (.clk_in(clk_in), .rst_in(rst_in),
  .reset_n_in(reset_n_in), .spi_sclk_in(spi_sclk_in), .spi_cs_n_in(spi_cs_n_in),
  .spi_si_in(spi_si_in), .spi_so_out(spi_so_out), .gpio_pins_in(gpio_pins_in),
  .gpio_pins_out(gpio_pins_out), .gpio_pins_oe_out(gpio_pins_oe_out),
  .gpio_pullup_en_out(gpio_pullup_en_out), .irq_n_out(irq_n_out),
  .irq_n_oe_out(irq_n_oe_out));
`default_nettype wire

// ### sgx_expander_bench.sv
`default_nettype none
module sgx_expander_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import sgx_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic reset_n_in = 1'b1;
  logic go = 1'b0;
  logic [15:0] tx = 16'h0000;
  logic [7:0] pins = 8'h00;
  logic done, sclk, cs_n, si, so, irq_oe, irq_n;
  logic [7:0] rx, lvl, oe, pu;
  int err_total = 0;
  int tests_run = 0;
  always #25 clk_in = ~clk_in;
  sgx_expander u_dut (.clk_in(clk_in), .rst_in(rst_in), .reset_n_in(reset_n_in),
    .spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .spi_si_in(si), .spi_so_out(so),
    .gpio_pins_in(pins), .gpio_pins_out(lvl), .gpio_pins_oe_out(oe),
    .gpio_pullup_en_out(pu), .irq_n_out(irq_n), .irq_n_oe_out(irq_oe));
  sgx_spi_master u_master (.clk_in(clk_in), .go_in(go), .tx_in(tx), .done_out(done),
    .rx_out(rx), .sclk_out(sclk), .cs_n_out(cs_n), .si_out(si), .so_in(so));
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic xfer(input logic [15:0] word);
    int n;
    go <= 1'b1;
    tx <= word;
    for (n = 0; n < 400 && done !== 1'b1; n++) @(posedge clk_in);
    if (n == 400) begin
      err_total++;
      conclude();
    end
    go <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [5:0] ofs, input logic [7:0] d);
    xfer({1'b0, ofs, 1'b0, d});
  endtask
  task automatic rd(input logic [5:0] ofs, input logic [7:0] exp, input string what);
    xfer({1'b1, ofs, 1'b0, 8'h00});
    chk(what, exp, rx);
  endtask
  task automatic pin(input logic [7:0] v, input logic exp);
    pins <= v;
    repeat (12) @(posedge clk_in);
    chk("irq", {7'h00, exp}, {7'h00, irq_oe});
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    chk("oe", 8'h00, oe);
    rd(OFS_DIR, 8'h00, "dir");
    wr(OFS_DIR, 8'hFF);
    wr(OFS_OUT_LVL, 8'hA5);
    wr(OFS_TRISTATE, 8'h0F);
    wr(OFS_PULLUP, 8'h3C);
    chk("lvl", 8'hA5, lvl);
    chk("oe", 8'hF0, oe);
    chk("pu", 8'h3C, pu);
    rd(OFS_OUT_LVL, 8'hA5, "lvl read");
    rd(6'h20, RD_UNMAPPED, "unmapped");
    xfer({1'b0, OFS_OUT_LVL, 1'b1, 8'h5A});
    chk("lvl reserved", 8'h5A, lvl);
    wr(OFS_DIR, 8'h00);
    wr(OFS_IRQ_EN, 8'h01);
    wr(OFS_RISE_EN, 8'h01);
    pin(8'h01, 1'b1);
    pin(8'h00, 1'b0);
    pin(8'h01, 1'b1);
    rd(OFS_INPUT, 8'h01, "state");
    chk("irq", 8'h00, {7'h00, irq_oe});
    wr(OFS_POLARITY, 8'hFF);
    rd(OFS_INPUT, 8'hFE, "inverted");
    wr(OFS_RISE_EN, 8'h00);
    wr(OFS_FALL_EN, 8'h01);
    pin(8'h00, 1'b0);
    pin(8'h01, 1'b1);
    chk("irq pin", 8'h00, {7'h00, irq_n});
    rd(OFS_IRQ_STAT, 8'h01, "pending");
    reset_n_in <= 1'b0;
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk("pu", 8'h00, pu);
    chk("irq", 8'h00, {7'h00, irq_oe});
    rd(OFS_POLARITY, 8'h00, "pol");
    rd(OFS_FALL_EN, 8'h00, "fall en");
    conclude();
  end
endmodule
`default_nettype wire

// ### sgx_pkg.sv
`default_nettype none
package sgx_pkg;
  localparam int NPINS = 8;
  localparam int CMD_RW_BIT = 7;
  localparam int CMD_OFS_HI = 6;
  localparam int CMD_OFS_LO = 1;
  localparam int BIT_CNT_W = 3;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int CLK_PERIOD_NS = 50;
  localparam int RST_MIN_NS = 40;
  // least time rounds up, never below one cycle
  localparam int RST_MIN_CYC_RAW = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_MIN_CYC = (RST_MIN_CYC_RAW < 1) ? 1 : RST_MIN_CYC_RAW;
  localparam logic [2:0] RST_CNT_LAST = RST_MIN_CYC[2:0];
  // register offsets (6-bit)
  localparam logic [5:0] OFS_INPUT = 6'h00;
  localparam logic [5:0] OFS_OUT_LVL = 6'h01;
  localparam logic [5:0] OFS_POLARITY = 6'h02;
  localparam logic [5:0] OFS_DIR = 6'h03;
  localparam logic [5:0] OFS_PULLUP = 6'h04;
  localparam logic [5:0] OFS_IRQ_EN = 6'h05;
  localparam logic [5:0] OFS_TRISTATE = 6'h06;
  localparam logic [5:0] OFS_IRQ_STAT = 6'h07;
  localparam logic [5:0] OFS_RISE_EN = 6'h08;
  localparam logic [5:0] OFS_FALL_EN = 6'h09;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ONES = 8'hFF;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  typedef enum logic [1:0] {SGX_CMD, SGX_DATA} sgx_phase_t;
endpackage
`default_nettype wire

// ### sgx_spi_master.sv
`default_nettype none
module sgx_spi_master (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [15:0] tx_in,
  output logic done_out,
  output logic [7:0] rx_out,
  output logic sclk_out,
  output logic cs_n_out,
  output logic si_out,
  input wire logic so_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {sclk_out, cs_n_out, si_out, done_out, rx_out} = 12'h400;
    forever begin
      @(posedge clk_in);
      if (go_in && !done_out) begin
        // pin changes land on clock edges: non-blocking keeps the sampling race-free
        cs_n_out <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
          #200 si_out <= tx_in[i];
          #200 sclk_out <= 1'b1;
          rx_out = {rx_out[6:0], so_in};
          #200 sclk_out <= 1'b0;
        end
        #200 cs_n_out <= 1'b1;
        // released data line must not keep looking valid
        si_out <= ~si_out;
        @(posedge clk_in) done_out <= 1'b1;
        @(posedge clk_in) done_out <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire
